/* File: logic/ucd_charger_ctrl.sv */
// Charger detection control, status and interrupt handler registers.
// Overview of operation
// [R1] High-current bit writable only in software mode; else mirrors detector.
// [R2] Low-current bit writable only in software mode; else mirrors detector.
// [R3] VBUS status is read-only, debounced 10 ms, and gates the detector.
// [R4] Result field: 00 none, 01 100 mA, 10 500 mA, 11 undefined.
// [R5] Software mode bypasses the detector; register bits drive the analog.
// [R6] Hardware enable starts detection, biases, raises charger-type event.
// [R7] Analog enable written by software outside hardware mode, driven by the detector in hardware mode.
// [R8] Contact, reference comparators and overvoltage status read-only copies.
// [R9] Three writable bits enable contact, voltage source, current source.
// [R10] Software sets battery-measure enable before requesting a battery reading.
// [R11] Status reads 1 when pending; write 1 releases, write 0 no effect.
// [R12] Mask resets to 1 and blocks the line; writing 0 unmasks.
// [R13] Edge pair selects falling, rising, both or none; rising after reset.
// [R14] Pending-disable set discards events arriving as software clears.
// [R15] Clear mode resets to 0: write clears; 1 selects clear on read.
// [R16] Clear-on-read clears on status read; else a fixed address clears all.
// [R17] Handler registers update synchronously on the bus clock.
// [R18] Interrupt line low while status set and unmasked.
`timescale 1ns/10ps
module ucd_charger_ctrl
   import ucd_pkg::*;
#(
   parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
   parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
)
(
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_rvalid_out,
   input wire logic vbus_presence_signal_in,
   input wire ucd_analog_in_t analog_in,
   output ucd_analog_out_t analog_out,
   output logic high_current_request_signal_out,
   output logic low_current_request_signal_out,
   output logic battery_measure_enable_out,
   output logic accessory_interrupt_line_n_out
);

   logic rst_sync1_r;
   logic rst_sync2_r;
   logic vbus_present_debounced;
   ucd_analog_in_t comp;
   ucd_state_t s_r;
   ucd_state_t s_nxt;

   // Reset is released through two flops so every state flop leaves reset on
   // the same edge.
   always_ff @(posedge mclk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         rst_sync1_r <= 1'b0;
         rst_sync2_r <= 1'b0;
      end
      else
      begin
         rst_sync1_r <= 1'b1;
         rst_sync2_r <= rst_sync1_r;
      end
   end

   ucd_pin_filter #(.STABLE_CYC(DEBOUNCE_CYCLES), .RESET_VAL(RST_LEVEL))
      u_vbus_filter (.mclk_in(mclk_in), .rst_n_in(rst_sync2_r),
      .ce_in(ce_in), .pin_in(vbus_presence_signal_in),
      .level_out(vbus_present_debounced)); // [R3]

   ucd_pin_filter #(.STABLE_CYC(COMP_STABLE_CYC), .RESET_VAL(RST_LEVEL))
      u_ovp_filter (.mclk_in(mclk_in), .rst_n_in(rst_sync2_r),
      .ce_in(ce_in), .pin_in(analog_in.ovp_precharge),
      .level_out(comp.ovp_precharge));

   ucd_pin_filter #(.STABLE_CYC(COMP_STABLE_CYC), .RESET_VAL(RST_CONTACT))
      u_minus_filter (.mclk_in(mclk_in), .rst_n_in(rst_sync2_r),
      .ce_in(ce_in), .pin_in(analog_in.minus_contact),
      .level_out(comp.minus_contact));

   ucd_pin_filter #(.STABLE_CYC(COMP_STABLE_CYC), .RESET_VAL(RST_CONTACT))
      u_plus_filter (.mclk_in(mclk_in), .rst_n_in(rst_sync2_r),
      .ce_in(ce_in), .pin_in(analog_in.plus_contact),
      .level_out(comp.plus_contact));

   ucd_pin_filter #(.STABLE_CYC(COMP_STABLE_CYC), .RESET_VAL(RST_LEVEL))
      u_vref_filter (.mclk_in(mclk_in), .rst_n_in(rst_sync2_r),
      .ce_in(ce_in), .pin_in(analog_in.line_vref),
      .level_out(comp.line_vref));

   // Detector drive terms, decoded from the current state.
   logic fsm_aen;
   logic fsm_cont;
   logic fsm_vsrc;
   logic fsm_high;
   logic fsm_low;
   logic hw_mode;

   always_comb
   begin
      hw_mode = s_r.hw_en && !s_r.sw_en;
      fsm_aen = (s_r.state == DS_CONTACT) || (s_r.state == DS_SETTLE);
      fsm_cont = (s_r.state == DS_CONTACT);
      fsm_vsrc = (s_r.state == DS_SETTLE);
      fsm_high = (s_r.result == RES_500);
      fsm_low = (s_r.result == RES_100);
   end

   logic evt_level;
   logic evt_hit;
   logic clr;
   logic [7:0] rd;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.rvalid = 1'b0;
      rd = 8'h00;
      clr = 1'b0;

      // Detector runs only with VBUS present, hardware enable set and
      // software control off.
      if (!(vbus_present_debounced && hw_mode)) // [R3] [R5]
      begin
         s_nxt.state = DS_IDLE;
         s_nxt.result = RES_NONE;
         s_nxt.cnt = 14'h0000;
      end
      else
      begin
         unique case (s_r.state)
            DS_IDLE:
            begin
               s_nxt.state = DS_CONTACT; // [R6]
            end
            DS_CONTACT:
            begin
               // Both data lines reading low means the plug has made contact.
               if (!comp.plus_contact && !comp.minus_contact)
               begin
                  s_nxt.state = DS_SETTLE;
                  s_nxt.cnt = 14'h0000;
               end
            end
            DS_SETTLE:
            begin
               if (s_r.cnt >= 14'(SETTLE_CYCLES - 1))
               begin
                  s_nxt.state = DS_DONE;
                  s_nxt.result = comp.line_vref ? RES_500 : RES_100; // [R4]
               end
               else
               begin
                  s_nxt.cnt = s_r.cnt + 14'h0001;
               end
            end
            DS_DONE:
            begin
               s_nxt.state = DS_DONE;
            end
         endcase
      end

      // Charger-type event: the result becoming non-zero, or returning to
      // zero when the charger goes away.
      evt_level = (s_r.result != RES_NONE); // [R6]
      s_nxt.evt_prev = evt_level;
      evt_hit = (s_r.edr_rise && evt_level && !s_r.evt_prev) ||
         (s_r.edr_fall && !evt_level && s_r.evt_prev); // [R13]

      // Status clear sources depend on the clear mode.
      if (reg_wr_in && (reg_addr_in == ADDR_ISR) && !s_r.clear_mode_select &&
         reg_wdata_in[INT_CHG_BIT]) // [R11] [R15]
      begin
         clr = 1'b1;
      end
      if (reg_rd_in && s_r.clear_mode_select && (reg_addr_in == ADDR_ISR)) // [R16]
      begin
         clr = 1'b1;
      end
      if (reg_rd_in && !s_r.clear_mode_select && (reg_addr_in == ADDR_CLEAR_ALL)) // [R16]
      begin
         clr = 1'b1;
      end

      // A new event beats a simultaneous clear unless pending events are
      // disabled, in which case the clear wins and the event is dropped.
      if (evt_hit && !(clr && s_r.pend)) // [R14]
      begin
         s_nxt.isr = 1'b1;
      end
      else if (clr)
      begin
         s_nxt.isr = 1'b0; // [R11]
      end

      if (reg_wr_in) // [R17]
      begin
         unique case (reg_addr_in)
            ADDR_DETECT:
            begin
               s_nxt.sw_en = reg_wdata_in[DET_SW_EN_BIT];
               s_nxt.hw_en = reg_wdata_in[DET_HW_EN_BIT];
               if (s_r.sw_en)
               begin
                  s_nxt.high_req = reg_wdata_in[DET_HIGH_BIT]; // [R1]
                  s_nxt.low_req = reg_wdata_in[DET_LOW_BIT]; // [R2]
               end
            end
            ADDR_SWCTRL:
            begin
               // In hardware mode the detector owns the analog enable.
               if (!hw_mode)
               begin
                  s_nxt.aen = reg_wdata_in[SW_AEN_BIT]; // [R7]
               end
               s_nxt.cont_en = reg_wdata_in[SW_CONT_BIT]; // [R9]
               s_nxt.vsrc_en = reg_wdata_in[SW_VSRC_BIT]; // [R9]
               s_nxt.isrc_en = reg_wdata_in[SW_ISRC_BIT]; // [R9]
            end
            ADDR_BATT:
            begin
               s_nxt.batt_en = reg_wdata_in[BATT_EN_BIT];
            end
            ADDR_IMR:
            begin
               s_nxt.imr = reg_wdata_in[INT_CHG_BIT]; // [R12]
            end
            ADDR_EDR:
            begin
               s_nxt.edr_rise = reg_wdata_in[EDR_RISE_BIT]; // [R13]
               s_nxt.edr_fall = reg_wdata_in[EDR_FALL_BIT]; // [R13]
            end
            ADDR_SIH:
            begin
               s_nxt.clear_mode_select = reg_wdata_in[SIH_COR_BIT]; // [R15]
               s_nxt.pend = reg_wdata_in[SIH_PEND_BIT]; // [R14]
               s_nxt.sih_rsv = reg_wdata_in[SIH_RSV_BIT];
            end
            ADDR_SPARE_SCRATCH:
            begin
               s_nxt.spare_scratch = reg_wdata_in;
            end
            default:
            begin
               s_nxt.spare_scratch = s_r.spare_scratch;
            end
         endcase
      end

      unique case (reg_addr_in)
         ADDR_DETECT:
         begin
            rd[DET_HIGH_BIT] = hw_mode ? fsm_high : s_r.high_req; // [R1]
            rd[DET_LOW_BIT] = hw_mode ? fsm_low : s_r.low_req; // [R2]
            rd[DET_VBUS_BIT] = vbus_present_debounced; // [R3]
            rd[DET_RES_LSB +: 2] = s_r.result; // [R4]
            rd[DET_SW_EN_BIT] = s_r.sw_en;
            rd[DET_HW_EN_BIT] = s_r.hw_en;
         end
         ADDR_SWCTRL:
         begin
            rd[SW_AEN_BIT] = hw_mode ? fsm_aen : s_r.aen; // [R7]
            rd[SW_OVP_BIT] = comp.ovp_precharge; // [R8]
            rd[SW_DM_BIT] = comp.minus_contact; // [R8]
            rd[SW_DP_BIT] = comp.plus_contact; // [R8]
            rd[SW_VDX_BIT] = comp.line_vref; // [R8]
            rd[SW_CONT_BIT] = s_r.cont_en;
            rd[SW_VSRC_BIT] = s_r.vsrc_en;
            rd[SW_ISRC_BIT] = s_r.isrc_en;
         end
         ADDR_BATT:
         begin
            rd[BATT_EN_BIT] = s_r.batt_en;
         end
         ADDR_ISR:
         begin
            rd[INT_CHG_BIT] = s_r.isr; // [R11]
         end
         ADDR_IMR:
         begin
            rd[INT_CHG_BIT] = s_r.imr;
         end
         ADDR_EDR:
         begin
            rd[EDR_RISE_BIT] = s_r.edr_rise;
            rd[EDR_FALL_BIT] = s_r.edr_fall;
         end
         ADDR_SIH:
         begin
            rd[SIH_COR_BIT] = s_r.clear_mode_select;
            rd[SIH_PEND_BIT] = s_r.pend;
            rd[SIH_RSV_BIT] = s_r.sih_rsv;
         end
         ADDR_SPARE_SCRATCH:
         begin
            rd = s_r.spare_scratch;
         end
         default:
         begin
            rd = 8'h00;
         end
      endcase

      if (reg_rd_in)
      begin
         s_nxt.rdata = rd;
         s_nxt.rvalid = 1'b1;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_sync2_r)
   begin
      if (!rst_sync2_r)
      begin
         s_r <= '{
            sw_en: 1'b0,
            hw_en: 1'b0,
            high_req: 1'b0,
            low_req: 1'b0,
            aen: 1'b0,
            cont_en: 1'b0,
            vsrc_en: 1'b0,
            isrc_en: 1'b0,
            batt_en: 1'b0,
            isr: 1'b0,
            imr: RST_IMR,
            edr_rise: RST_EDR_RISE,
            edr_fall: RST_EDR_FALL,
            clear_mode_select: RST_SIH_COR,
            pend: RST_SIH_PEND,
            sih_rsv: RST_SIH_RSV,
            spare_scratch: RST_SPARE,
            state: DS_IDLE,
            result: RES_NONE,
            cnt: 14'h0000,
            evt_prev: 1'b0,
            rdata: 8'h00,
            rvalid: 1'b0
         };
      end
      else if (ce_in) // [R17]
      begin
         s_r <= s_nxt;
      end
   end

   // Software mode drives the analog straight from the register bits.
   always_comb
   begin
      analog_out.bias_enable = s_r.hw_en; // [R6]
      analog_out.analog_detection_enable =
         hw_mode ? fsm_aen : s_r.aen; // [R7]
      analog_out.contact_comparator_enable =
         hw_mode ? fsm_cont : (s_r.sw_en && s_r.cont_en); // [R5] [R9]
      analog_out.voltage_source_enable =
         hw_mode ? fsm_vsrc : (s_r.sw_en && s_r.vsrc_en); // [R5] [R9]
      analog_out.current_source_enable =
         !hw_mode && s_r.sw_en && s_r.isrc_en; // [R5] [R9]
   end

   assign high_current_request_signal_out =
      s_r.sw_en ? s_r.high_req : (s_r.hw_en && fsm_high); // [R1]
   assign low_current_request_signal_out =
      s_r.sw_en ? s_r.low_req : (s_r.hw_en && fsm_low); // [R2]
   assign battery_measure_enable_out = s_r.batt_en; // [R10]
   assign accessory_interrupt_line_n_out = !(s_r.isr && !s_r.imr); // [R18]
   assign reg_rdata_out = s_r.rdata;
   assign reg_rvalid_out = s_r.rvalid;

endmodule : ucd_charger_ctrl

/* File: logic/ucd_pkg.sv */
// Shared constants, register map and carrier types for the charger detector.
package ucd_pkg;

   // Clock rate and derived timing counts.
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned DEBOUNCE_MS = 10;
   localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
   localparam int unsigned SETTLE_US = 100;
   localparam int unsigned SETTLE_CYC = (CLK_HZ / 1_000_000) * SETTLE_US;
   localparam int unsigned COMP_STABLE_CYC = 1;

   // Register byte addresses.
   localparam logic [7:0] ADDR_DETECT = 8'h76;
   localparam logic [7:0] ADDR_SWCTRL = 8'h77;
   localparam logic [7:0] ADDR_BATT = 8'h78;
   localparam logic [7:0] ADDR_ISR = 8'h79;
   localparam logic [7:0] ADDR_IMR = 8'h7a;
   localparam logic [7:0] ADDR_EDR = 8'h7e;
   localparam logic [7:0] ADDR_SIH = 8'h7f;
   localparam logic [7:0] ADDR_SPARE_READONLY = 8'h83;
   localparam logic [7:0] ADDR_SPARE_SCRATCH = 8'h84;
   localparam logic [7:0] ADDR_CLEAR_ALL = 8'h83;

   // Field positions of charger_detect_control.
   localparam int unsigned DET_HIGH_BIT = 6;
   localparam int unsigned DET_LOW_BIT = 5;
   localparam int unsigned DET_VBUS_BIT = 4;
   localparam int unsigned DET_RES_LSB = 2;
   localparam int unsigned DET_SW_EN_BIT = 1;
   localparam int unsigned DET_HW_EN_BIT = 0;

   // Field positions of charger_software_control_status.
   localparam int unsigned SW_AEN_BIT = 7;
   localparam int unsigned SW_OVP_BIT = 6;
   localparam int unsigned SW_DM_BIT = 5;
   localparam int unsigned SW_DP_BIT = 4;
   localparam int unsigned SW_VDX_BIT = 3;
   localparam int unsigned SW_CONT_BIT = 2;
   localparam int unsigned SW_VSRC_BIT = 1;
   localparam int unsigned SW_ISRC_BIT = 0;

   // Field positions of the battery, handler and edge registers.
   localparam int unsigned BATT_EN_BIT = 0;
   localparam int unsigned INT_CHG_BIT = 0;
   localparam int unsigned EDR_RISE_BIT = 1;
   localparam int unsigned EDR_FALL_BIT = 0;
   localparam int unsigned SIH_COR_BIT = 2;
   localparam int unsigned SIH_PEND_BIT = 1;
   localparam int unsigned SIH_RSV_BIT = 0;

   // Reset values.
   localparam logic RST_IMR = 1'b1;
   localparam logic RST_EDR_RISE = 1'b1;
   localparam logic RST_EDR_FALL = 1'b0;
   localparam logic RST_SIH_COR = 1'b0;
   localparam logic RST_SIH_PEND = 1'b0;
   localparam logic RST_SIH_RSV = 1'b1;
   localparam logic [7:0] RST_SPARE = 8'h00;
   localparam logic RST_CONTACT = 1'b1;
   localparam logic RST_LEVEL = 1'b0;

   // Detection result codes.
   localparam logic [1:0] RES_NONE = 2'h0;
   localparam logic [1:0] RES_100 = 2'h1;
   localparam logic [1:0] RES_500 = 2'h2;

   typedef enum logic [1:0] {
      DS_IDLE,
      DS_CONTACT,
      DS_SETTLE,
      DS_DONE
   } ucd_det_state_t;

   // Comparator and status levels coming from the analog detector.
   typedef struct packed {
      logic ovp_precharge;
      logic minus_contact;
      logic plus_contact;
      logic line_vref;
   } ucd_analog_in_t;

   // Enables going to the analog detector.
   typedef struct packed {
      logic bias_enable;
      logic analog_detection_enable;
      logic contact_comparator_enable;
      logic voltage_source_enable;
      logic current_source_enable;
   } ucd_analog_out_t;

   typedef struct packed {
      logic [2:0] sync;
      logic level;
      logic [19:0] cnt;
   } ucd_filt_t;

   typedef struct packed {
      logic sw_en;
      logic hw_en;
      logic high_req;
      logic low_req;
      logic aen;
      logic cont_en;
      logic vsrc_en;
      logic isrc_en;
      logic batt_en;
      logic isr;
      logic imr;
      logic edr_rise;
      logic edr_fall;
      logic clear_mode_select;
      logic pend;
      logic sih_rsv;
      logic [7:0] spare_scratch;
      ucd_det_state_t state;
      logic [1:0] result;
      logic [13:0] cnt;
      logic evt_prev;
      logic [7:0] rdata;
      logic rvalid;
   } ucd_state_t;

endpackage : ucd_pkg

/* File: logic/ucd_pin_filter.sv */
// Three-stage synchroniser with agreement check and stability counter.
`timescale 1ns/10ps
module ucd_pin_filter
   import ucd_pkg::*;
#(
   parameter int unsigned STABLE_CYC = 1,
   parameter logic RESET_VAL = 1'b0
)
(
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic pin_in,
   output logic level_out
);

   ucd_filt_t s_r;
   ucd_filt_t s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.sync = {s_r.sync[1:0], pin_in};
      // Only the second and third stages are compared; the first may be
      // metastable.
      if ((s_r.sync[1] == s_r.sync[2]) && (s_r.sync[2] != s_r.level))
      begin
         if (s_r.cnt >= 20'(STABLE_CYC - 1))
         begin
            s_nxt.level = s_r.sync[2];
            s_nxt.cnt = 20'h00000;
         end
         else
         begin
            s_nxt.cnt = s_r.cnt + 20'h00001;
         end
      end
      else
      begin
         s_nxt.cnt = 20'h00000;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         s_r <= '{sync: {3{RESET_VAL}}, level: RESET_VAL, cnt: 20'h00000};
      end
      else if (ce_in)
      begin
         s_r <= s_nxt;
      end
   end

   assign level_out = s_r.level;

endmodule : ucd_pin_filter

/* File: test/ucd_charger_ctrl_chk.sv */
// Port-level assertions for the charger detection controller.
`timescale 1ns/10ps
module ucd_charger_ctrl_chk
   import ucd_pkg::*;
(
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic reg_rvalid_out,
   input wire logic vbus_presence_signal_in,
   input wire ucd_analog_in_t analog_in,
   input wire ucd_analog_out_t analog_out,
   input wire logic high_current_request_signal_out,
   input wire logic low_current_request_signal_out,
   input wire logic battery_measure_enable_out,
   input wire logic accessory_interrupt_line_n_out
);
   logic wr;
   logic rd;
   logic sw_r;
   logic hw_r;
   logic cor_r;
   assign wr = ce_in && reg_wr_in;
   assign rd = ce_in && reg_rd_in;
   always_ff @(posedge mclk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         sw_r <= 1'b0;
         hw_r <= 1'b0;
         cor_r <= RST_SIH_COR;
      end
      else if (wr && reg_addr_in == ADDR_DETECT)
      begin
         sw_r <= reg_wdata_in[DET_SW_EN_BIT];
         hw_r <= reg_wdata_in[DET_HW_EN_BIT];
      end
      else if (wr && reg_addr_in == ADDR_SIH)
         cor_r <= reg_wdata_in[SIH_COR_BIT];
   end
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!resetn_in);
   a_read_answer: assert property (rd |=> reg_rvalid_out)
      else $error("read strobe got no answer");
   a_answer_cause: assert property (reg_rvalid_out |-> $past(rd))
      else $error("read answer without a read");
   a_rdata_hold: assert property (!reg_rvalid_out |-> $stable(reg_rdata_out))
      else $error("read data changed without a read");
   a_req_write: assert property (wr && reg_addr_in == ADDR_DETECT && sw_r
      && reg_wdata_in[DET_SW_EN_BIT] |=>
      high_current_request_signal_out == $past(reg_wdata_in[DET_HIGH_BIT])
      && low_current_request_signal_out == $past(reg_wdata_in[DET_LOW_BIT]))
      else $error("request pins do not follow the written bits");
   a_req_refused: assert property (wr && reg_addr_in == ADDR_DETECT && !sw_r
      && !hw_r && !reg_wdata_in[DET_SW_EN_BIT] |=>
      !high_current_request_signal_out && !low_current_request_signal_out)
      else $error("request pins rose outside software mode");
   a_sw_drive: assert property (wr && reg_addr_in == ADDR_SWCTRL && sw_r |=>
      analog_out[3:0] == $past({reg_wdata_in[7], reg_wdata_in[2:0]}))
      else $error("analog enables do not follow the register");
   a_batt_follow: assert property (wr && reg_addr_in == ADDR_BATT |=>
      battery_measure_enable_out == $past(reg_wdata_in[BATT_EN_BIT]))
      else $error("battery enable does not follow the register");
   a_mask_gate: assert property (wr && reg_addr_in == ADDR_IMR
      && reg_wdata_in[INT_CHG_BIT] |=> accessory_interrupt_line_n_out)
      else $error("masked source still drives the line");
   a_write_clear: assert property (wr && reg_addr_in == ADDR_ISR && !cor_r
      && reg_wdata_in[INT_CHG_BIT] |=> accessory_interrupt_line_n_out)
      else $error("write of one did not release the line");
   a_read_clear: assert property (rd && reg_addr_in == ADDR_ISR && cor_r
      |=> accessory_interrupt_line_n_out)
      else $error("status read did not release the line");
   a_clear_all: assert property (rd && reg_addr_in == ADDR_CLEAR_ALL && !cor_r
      |=> accessory_interrupt_line_n_out)
      else $error("clear-all read did not release the line");
   a_bias_on: assert property (hw_r && !sw_r |-> analog_out.bias_enable)
      else $error("bias off while hardware detection is on");
   c_hw_irq: cover property (hw_r && !accessory_interrupt_line_n_out);
   c_res_high: cover property (reg_rvalid_out && reg_rdata_out[3:2] == RES_500);
   c_cor_read: cover property (rd && reg_addr_in == ADDR_ISR && cor_r);
endmodule : ucd_charger_ctrl_chk

bind ucd_charger_ctrl ucd_charger_ctrl_chk chk_i (
   .mclk_in, .resetn_in, .ce_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
   .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .vbus_presence_signal_in,
   .analog_in, .analog_out, .high_current_request_signal_out,
   .low_current_request_signal_out, .battery_measure_enable_out,
   .accessory_interrupt_line_n_out
);

/* File: test/ucd_analog_model.sv */
// Behavioural model of the analog charger detector and its comparators.
`timescale 1ns/10ps
module ucd_analog_model
   import ucd_pkg::*;
(
   input wire ucd_analog_out_t enables_in,
   input wire logic attached_in,
   input wire logic high_kind_in,
   input wire logic ovp_in,
   output ucd_analog_in_t levels_out
);
   logic touch;
   logic drive;
   // Comparators idle high; contact pulls them low only while enabled.
   assign touch = enables_in.contact_comparator_enable && attached_in;
   // The reference trips only while the source drives a high-current port.
   assign drive = enables_in.voltage_source_enable && attached_in;
   assign levels_out.ovp_precharge = ovp_in;
   assign levels_out.minus_contact = !touch;
   assign levels_out.plus_contact = !touch;
   assign levels_out.line_vref = drive && high_kind_in;
endmodule : ucd_analog_model

/* File: test/usb_charger_detect_ctrl_bench.sv */
// Self-checking bench for the charger detection controller.
`timescale 1ns/10ps
module usb_charger_detect_ctrl_bench
   import ucd_pkg::*;
;
   logic clk, rstn, ce, wr, rd, rvalid, vbus, att, hk, ovp;
   logic hreq, lreq, batt, irq_n;
   logic [7:0] addr, wdata, rdata;
   ucd_analog_in_t lv;
   ucd_analog_out_t ao;
   int num_errors = 0;
   int tests_run = 0;
   logic [7:0] ra [10] = '{ADDR_DETECT, ADDR_SWCTRL, ADDR_BATT, ADDR_ISR,
      ADDR_IMR, ADDR_EDR, ADDR_SIH, ADDR_SPARE_READONLY, ADDR_SPARE_SCRATCH, 8'h80};
   logic [7:0] rv [10] = '{8'h00, 8'h30, 8'h00, 8'h00, 8'h01, 8'h02, 8'h01,
      8'h00, 8'h00, 8'h00};

   ucd_charger_ctrl #(.DEBOUNCE_CYCLES(8), .SETTLE_CYCLES(12)) dut (
      .mclk_in(clk), .resetn_in(rstn), .ce_in(ce), .reg_addr_in(addr),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
      .vbus_presence_signal_in(vbus), .analog_in(lv), .analog_out(ao),
      .high_current_request_signal_out(hreq),
      .low_current_request_signal_out(lreq),
      .battery_measure_enable_out(batt),
      .accessory_interrupt_line_n_out(irq_n)
   );
   ucd_analog_model far (.enables_in(ao), .attached_in(att),
      .high_kind_in(hk), .ovp_in(ovp), .levels_out(lv));

   task automatic chk(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      chk("read valid", 8'h01, {7'h0, rvalid});
      d = rdata;
   endtask : rd_reg
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
      input string what);
      logic [7:0] d;
      rd_reg(a, d);
      chk(what, e, d);
   endtask : rd_chk
   task automatic wait_res(input logic want);
      logic [7:0] d;
      d = want ? 8'h00 : 8'h0c;
      for (int i = 0; i < 400 && ((d[3:2] != 2'h0) != want); i++)
         rd_reg(ADDR_DETECT, d);
   endtask : wait_res
   task report_and_stop;
      $display("checks %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      repeat (30000) @(posedge clk);
      num_errors++;
      report_and_stop();
   end
   initial
   begin
      {rstn, wr, rd, vbus, att, hk, ovp} = 7'h0;
      ce = 1'b1;
      addr = 8'h00;
      wdata = 8'h00;
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      repeat (3) @(negedge clk);
      for (int i = 0; i < 10; i++)
         rd_chk(ra[i], rv[i], "reset value");
      wr_reg(ADDR_SPARE_SCRATCH, 8'ha5);
      wr_reg(ADDR_SPARE_READONLY, 8'h5a);
      rd_chk(ADDR_SPARE_SCRATCH, 8'ha5, "spare scratch");
      rd_chk(ADDR_SPARE_READONLY, 8'h00, "spare read-only");
      wr_reg(ADDR_DETECT, 8'h60);
      rd_chk(ADDR_DETECT, 8'h00, "refused requests");
      wr_reg(ADDR_DETECT, 8'h02);
      wr_reg(ADDR_DETECT, 8'h62);
      rd_chk(ADDR_DETECT, 8'h62, "software requests");
      chk("request pins", 8'h03, {6'h0, hreq, lreq});
      att = 1'b1;
      hk = 1'b1;
      wr_reg(ADDR_SWCTRL, 8'h87);
      chk("analog enables", 8'h0f, {3'h0, ao});
      repeat (8) @(negedge clk);
      rd_chk(ADDR_SWCTRL, 8'h8f, "comparator copies");
      ovp = 1'b1;
      repeat (8) @(negedge clk);
      rd_chk(ADDR_SWCTRL, 8'hcf, "overvoltage copy");
      ovp = 1'b0;
      att = 1'b0;
      wr_reg(ADDR_SWCTRL, 8'h00);
      wr_reg(ADDR_BATT, 8'hff);
      rd_chk(ADDR_BATT, 8'h01, "battery enable");
      chk("battery pin", 8'h01, {7'h0, batt});
      wr_reg(ADDR_DETECT, 8'h00);
      wr_reg(ADDR_IMR, 8'h00);
      wr_reg(ADDR_DETECT, 8'h01);
      for (int k = 0; k < 2; k++)
      begin
         hk = (k == 0);
         vbus = 1'b1;
         att = 1'b1;
         wait_res(1'b1);
         rd_chk(ADDR_DETECT, k ? 8'h35 : 8'h59, "result");
         chk("hw requests", k ? 8'h01 : 8'h02, {6'h0, hreq, lreq});
         chk("line asserted", 8'h00, {7'h0, irq_n});
         if (k == 0)
         begin
            wr_reg(ADDR_ISR, 8'h00);
            chk("line kept", 8'h00, {7'h0, irq_n});
            wr_reg(ADDR_ISR, 8'h01);
            chk("write clear", 8'h01, {7'h0, irq_n});
         end
         else
         begin
            wr_reg(ADDR_SIH, 8'h05);
            rd_chk(ADDR_ISR, 8'h01, "status on read");
            rd_chk(ADDR_ISR, 8'h00, "cleared by read");
            chk("read clear", 8'h01, {7'h0, irq_n});
         end
         vbus = 1'b0;
         att = 1'b0;
         wait_res(1'b0);
         chk("no falling event", 8'h01, {7'h0, irq_n});
      end
      wr_reg(ADDR_SIH, 8'h01);
      wr_reg(ADDR_EDR, 8'h01);
      vbus = 1'b1;
      att = 1'b1;
      wait_res(1'b1);
      chk("rise ignored", 8'h01, {7'h0, irq_n});
      vbus = 1'b0;
      att = 1'b0;
      wait_res(1'b0);
      chk("fall detected", 8'h00, {7'h0, irq_n});
      wr_reg(ADDR_IMR, 8'h01);
      chk("masked line", 8'h01, {7'h0, irq_n});
      rd_chk(ADDR_SPARE_READONLY, 8'h00, "clear-all read");
      wr_reg(ADDR_IMR, 8'h00);
      chk("cleared all", 8'h01, {7'h0, irq_n});
      rd_chk(ADDR_ISR, 8'h00, "status empty");
      report_and_stop();
   end
endmodule : usb_charger_detect_ctrl_bench
